// ---- design/tws_pkg.sv ----
package tws_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] DATA_OFF = 8'h08;

	// Control register bit positions
	localparam int CTRL_FLAG_POS  = 7;
	localparam int CTRL_START_POS = 5;
	localparam int CTRL_STOP_POS  = 4;
	localparam int CTRL_WCOL_POS  = 3;
	localparam int CTRL_EN_POS    = 2;
	localparam int CTRL_IE_POS    = 0;

	// Status register field positions
	localparam int STAT_CODE_LSB = 3;
	localparam int STAT_PS_LSB   = 0;

	// Five-bit status codes, upper bits of the status register
	localparam logic [4:0] CODE_START     = 5'h01;
	localparam logic [4:0] CODE_ADDR_ACK  = 5'h03;
	localparam logic [4:0] CODE_ADDR_NACK = 5'h04;
	localparam logic [4:0] CODE_DATA_ACK  = 5'h05;
	localparam logic [4:0] CODE_DATA_NACK = 5'h06;
	localparam logic [4:0] CODE_IDLE      = 5'h1F;

	// Reset values
	localparam logic [7:0] DATA_RST = 8'hFF;
	localparam logic [1:0] PS_RST   = 2'h0;

	// Timing: a quarter of one bus bit period
	localparam int CLK_NS      = 50;
	localparam int QUARTER_NS  = 2500;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int LAST_BIT    = 8;

	// Bus engine states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_BYTE  = 4'b0100,
		ST_STOP  = 4'b1000
	} tws_state_e;

endpackage

// ---- design/tws_master.sv ----
// What this block does
// - Flag rises after every handled START and byte, not after STOP
// - Interrupt only with local and global enables
// - Flag set means status shows bus state
// - Writing one clears flag, zero keeps it
// - No new bus operation while flag set
// - Clearing with start request sends START
// - START done sets flag and START code
// - Address sent sets flag, code shows ack
// - Data sent sets flag, code shows ack
// - STOP done leaves the flag clear
// - Clock line held low while flag set, enabled and bus owned
// - Perform exactly the operation just written
// - Start request bit clears after START sent
// - Status code in bits 7..3, prescaler low
`timescale 1ns/10ps
`default_nettype none

module tws_master #(
	parameter int QUARTER = tws_pkg::QUARTER_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        global_irq_en_i,
	output logic             irq_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o
);

	if (QUARTER < 1 || QUARTER > 65535)
	begin : g_chk
		$error("QUARTER must lie in 1..65535");
	end

	localparam logic [15:0] TMR_LOAD = 16'(QUARTER - 1);

	tws_pkg::tws_state_e state_ff;
	tws_pkg::tws_state_e nxt_state;
	logic        flag_ff;
	logic        start_ff;
	logic        stop_ff;
	logic        en_ff;
	logic        ie_ff;
	logic        wcol_ff;
	logic        go_ff;
	logic        owned_ff;
	logic        addr_next_ff;
	logic        ack_ff;
	logic        irq_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [1:0]  ps_ff;
	logic [4:0]  code_ff;
	logic [7:0]  data_ff;
	logic [31:0] prdata_ff;
	logic [1:0]  phase_ff;
	logic [3:0]  bit_ff;
	logic [15:0] tmr_ff;
	logic        scl_oe_ff;
	logic        sda_oe_ff;
	logic        nxt_scl_oe;
	logic        nxt_sda_oe;
	logic        pin_lvl_ff;
	logic [1:0]  scl_sync_ff;
	logic [1:0]  sda_sync_ff;
	logic        scl_s;
	logic        sda_s;
	logic        wr;
	logic        rd;
	logic        ctrl_wr;
	logic        stat_wr;
	logic        data_wr;
	logic        clr_req;
	logic        stall;
	logic        step;
	logic        ph_end;
	logic        launch;
	logic        start_done;
	logic        byte_done;
	logic        stop_done;
	logic        mapped;

	// Two-flop synchronisers for the bus lines
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
		end
	end
	assign scl_s = scl_sync_ff[1];
	assign sda_s = sda_sync_ff[1];

	// APB decode, one access cycle
	assign wr      = psel_i & penable_i & pready_ff & pwrite_i;
	assign rd      = psel_i & ~penable_i & ~pwrite_i;
	assign ctrl_wr = wr & (paddr_i == tws_pkg::CTRL_OFF);
	assign stat_wr = wr & (paddr_i == tws_pkg::STAT_OFF);
	assign data_wr = wr & (paddr_i == tws_pkg::DATA_OFF);
	assign clr_req = ctrl_wr & pwdata_i[tws_pkg::CTRL_FLAG_POS];
	assign mapped  = (paddr_i == tws_pkg::CTRL_OFF) |
			(paddr_i == tws_pkg::STAT_OFF) |
			(paddr_i == tws_pkg::DATA_OFF);

	// Bus answer: ready one cycle after setup
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end
		else
		begin
			pready_ff  <= psel_i & ~penable_i;
			pslverr_ff <= psel_i & ~penable_i & ~mapped;
			if (rd)
			begin
				unique case (paddr_i)
					tws_pkg::CTRL_OFF: prdata_ff <= {24'h0, flag_ff,
						1'b0, start_ff, stop_ff, wcol_ff, en_ff,
						1'b0, ie_ff};
					tws_pkg::STAT_OFF: prdata_ff <= {24'h0, code_ff,
						1'b0, ps_ff};
					tws_pkg::DATA_OFF: prdata_ff <= {24'h0, data_ff};
					default:           prdata_ff <= 32'h0;
				endcase
			end
		end
	end

	// Engine step and event decode
	assign stall      = ~scl_oe_ff & ~scl_s;
	assign step       = (state_ff != tws_pkg::ST_IDLE) &&
			(tmr_ff == 16'h0) && !stall;
	assign ph_end     = step && (phase_ff == 2'h3);
	assign start_done = ph_end && (state_ff == tws_pkg::ST_START);
	assign byte_done  = ph_end && (state_ff == tws_pkg::ST_BYTE) &&
			(bit_ff == 4'(tws_pkg::LAST_BIT));
	assign stop_done  = ph_end && (state_ff == tws_pkg::ST_STOP);
	assign launch     = (state_ff == tws_pkg::ST_IDLE) && go_ff &&
			!flag_ff && en_ff;

	// Completion flag; hardware set wins over clear
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			flag_ff <= 1'b0;
		else if (start_done || byte_done)
			flag_ff <= 1'b1;
		else if (clr_req)
			flag_ff <= 1'b0;
	end

	// Control bits and pending launch
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			start_ff <= 1'b0;
			stop_ff  <= 1'b0;
			en_ff    <= 1'b0;
			ie_ff    <= 1'b0;
			go_ff    <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
			begin
				en_ff <= pwdata_i[tws_pkg::CTRL_EN_POS];
				ie_ff <= pwdata_i[tws_pkg::CTRL_IE_POS];
			end
			if (start_done)
				start_ff <= 1'b0;
			else if (ctrl_wr)
				start_ff <= pwdata_i[tws_pkg::CTRL_START_POS];
			if (stop_done)
				stop_ff <= 1'b0;
			else if (ctrl_wr)
				stop_ff <= pwdata_i[tws_pkg::CTRL_STOP_POS];
			if (clr_req && pwdata_i[tws_pkg::CTRL_EN_POS])
				go_ff <= 1'b1;
			else if (launch || !en_ff)
				go_ff <= 1'b0;
		end
	end

	// Prescaler field, stored only
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ps_ff <= tws_pkg::PS_RST;
		else if (stat_wr)
			ps_ff <= pwdata_i[tws_pkg::STAT_PS_LSB +: 2];
	end

	// Shared address/data register with write collision
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			data_ff <= tws_pkg::DATA_RST;
			wcol_ff <= 1'b0;
		end
		else
		begin
			if (data_wr && flag_ff)
			begin
				data_ff <= pwdata_i[7:0];
				wcol_ff <= 1'b0;
			end
			else if (data_wr)
				wcol_ff <= 1'b1;
			if (step && state_ff == tws_pkg::ST_BYTE &&
					phase_ff == 2'h2 &&
					bit_ff != 4'(tws_pkg::LAST_BIT))
				data_ff <= {data_ff[6:0], sda_s};
		end
	end

	// Next state of the bus engine
	always_comb
	begin
		nxt_state = state_ff;
		if (!en_ff)
			nxt_state = tws_pkg::ST_IDLE;
		else
		begin
			unique case (state_ff)
				tws_pkg::ST_IDLE:
				begin
					if (launch && start_ff)
						nxt_state = tws_pkg::ST_START;
					else if (launch && stop_ff && owned_ff)
						nxt_state = tws_pkg::ST_STOP;
					else if (launch && owned_ff)
						nxt_state = tws_pkg::ST_BYTE;
				end
				tws_pkg::ST_START:
					if (start_done)
						nxt_state = tws_pkg::ST_IDLE;
				tws_pkg::ST_BYTE:
					if (byte_done)
						nxt_state = tws_pkg::ST_IDLE;
				tws_pkg::ST_STOP:
					if (stop_done)
						nxt_state = tws_pkg::ST_IDLE;
				default:
					nxt_state = tws_pkg::ST_IDLE;
			endcase
		end
	end

	// Engine state, phase, bit and quarter timer
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_ff <= tws_pkg::ST_IDLE;
			phase_ff <= 2'h0;
			bit_ff   <= 4'h0;
			tmr_ff   <= 16'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff)
			begin
				phase_ff <= 2'h0;
				bit_ff   <= 4'h0;
				tmr_ff   <= TMR_LOAD;
			end
			else if (tmr_ff != 16'h0)
				tmr_ff <= tmr_ff - 16'h1;
			else if (step)
			begin
				phase_ff <= phase_ff + 2'h1;
				tmr_ff   <= TMR_LOAD;
				if (ph_end)
					bit_ff <= bit_ff + 4'h1;
			end
		end
	end

	// Bus ownership, address tracking and ack capture
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			owned_ff     <= 1'b0;
			addr_next_ff <= 1'b0;
			ack_ff       <= 1'b1;
		end
		else
		begin
			if (!en_ff || stop_done)
				owned_ff <= 1'b0;
			else if (start_done)
				owned_ff <= 1'b1;
			if (start_done)
				addr_next_ff <= 1'b1;
			else if (byte_done)
				addr_next_ff <= 1'b0;
			if (step && state_ff == tws_pkg::ST_BYTE &&
					phase_ff == 2'h2 &&
					bit_ff == 4'(tws_pkg::LAST_BIT))
				ack_ff <= sda_s;
		end
	end

	// Status code posted with each flag event
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			code_ff <= tws_pkg::CODE_IDLE;
		else if (start_done)
			code_ff <= tws_pkg::CODE_START;
		else if (byte_done && addr_next_ff)
			code_ff <= ack_ff ? tws_pkg::CODE_ADDR_NACK
					: tws_pkg::CODE_ADDR_ACK;
		else if (byte_done)
			code_ff <= ack_ff ? tws_pkg::CODE_DATA_NACK
					: tws_pkg::CODE_DATA_ACK;
		else if (launch)
			code_ff <= tws_pkg::CODE_IDLE;
	end

	// Line drive per state and phase
	always_comb
	begin
		nxt_scl_oe = scl_oe_ff;
		nxt_sda_oe = sda_oe_ff;
		unique case (state_ff)
			// Keep SCL low through the launch gap after a clear
			tws_pkg::ST_IDLE:
				nxt_scl_oe = (flag_ff | go_ff) & owned_ff;
			tws_pkg::ST_START:
			begin
				nxt_scl_oe = (phase_ff == 2'h0) ? owned_ff
						: (phase_ff == 2'h3);
				nxt_sda_oe = phase_ff[1];
			end
			tws_pkg::ST_BYTE:
			begin
				nxt_scl_oe = (phase_ff == 2'h0) |
						(phase_ff == 2'h3);
				if (phase_ff == 2'h0)
					nxt_sda_oe = (bit_ff != 4'(tws_pkg::LAST_BIT))
							& ~data_ff[7];
			end
			tws_pkg::ST_STOP:
			begin
				nxt_scl_oe = (phase_ff == 2'h0);
				nxt_sda_oe = ~phase_ff[1];
			end
			default:
			begin
				nxt_scl_oe = 1'b0;
				nxt_sda_oe = 1'b0;
			end
		endcase
		if (!en_ff)
		begin
			nxt_scl_oe = 1'b0;
			nxt_sda_oe = 1'b0;
		end
	end

	// Open-drain enables, interrupt and pin level
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_oe_ff  <= 1'b0;
			sda_oe_ff  <= 1'b0;
			irq_ff     <= 1'b0;
			pin_lvl_ff <= 1'b0;
		end
		else
		begin
			scl_oe_ff  <= nxt_scl_oe;
			sda_oe_ff  <= nxt_sda_oe;
			irq_ff     <= flag_ff & ie_ff & global_irq_en_i;
			pin_lvl_ff <= 1'b0;
		end
	end

	assign prdata_o  = prdata_ff;
	assign pready_o  = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign irq_o     = irq_ff;
	assign scl_o     = pin_lvl_ff;
	assign sda_o     = pin_lvl_ff;
	assign scl_oe_o  = scl_oe_ff;
	assign sda_oe_o  = sda_oe_ff;

	// Checks on the engine and flag handshake
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_go_start;
		clr_req && pwdata_i[tws_pkg::CTRL_EN_POS] &&
				pwdata_i[tws_pkg::CTRL_START_POS] &&
				state_ff == tws_pkg::ST_IDLE && !start_done &&
				!byte_done;
	endsequence

	sequence s_flag_held;
		flag_ff && owned_ff && en_ff ##1 flag_ff && en_ff;
	endsequence

	AST_START_FLAG: assert property (
		start_done |=> flag_ff && code_ff == tws_pkg::CODE_START)
		else $error("START done without flag and code");
	AST_STOP_NOFLAG: assert property (
		stop_done && !clr_req |=> flag_ff == $past(flag_ff))
		else $error("flag changed by STOP");
	AST_FLAG_CLEAR: assert property (
		clr_req && !start_done && !byte_done |=> !flag_ff)
		else $error("flag not cleared by write of one");
	AST_FLAG_KEEP: assert property (
		ctrl_wr && !pwdata_i[tws_pkg::CTRL_FLAG_POS] && flag_ff
		|=> flag_ff)
		else $error("flag lost on write of zero");
	AST_NO_LAUNCH: assert property (
		flag_ff && state_ff == tws_pkg::ST_IDLE
		|=> state_ff == tws_pkg::ST_IDLE)
		else $error("operation begun while flag set");
	AST_SCL_HELD: assert property (
		s_flag_held |=> scl_oe_ff)
		else $error("clock released while flag set");
	AST_IRQ_GATE: assert property (
		(!ie_ff || !global_irq_en_i || !flag_ff) |=> !irq_ff)
		else $error("interrupt without both enables");
	AST_START_GO: assert property (
		s_go_start ##1 !flag_ff |-> ##[0:1] state_ff == tws_pkg::ST_START)
		else $error("START not begun after flag clear");
	AST_START_BITCLR: assert property (
		start_done |=> !start_ff)
		else $error("start request not cleared");
	AST_ADDR_CODE: assert property (
		byte_done && addr_next_ff |=> flag_ff &&
		code_ff == ($past(ack_ff) ? tws_pkg::CODE_ADDR_NACK
				: tws_pkg::CODE_ADDR_ACK))
		else $error("address status code wrong");
	AST_DATA_CODE: assert property (
		byte_done && !addr_next_ff |=> flag_ff &&
		code_ff == ($past(ack_ff) ? tws_pkg::CODE_DATA_NACK
				: tws_pkg::CODE_DATA_ACK))
		else $error("data status code wrong");
	AST_FLAG_CODE: assert property (
		flag_ff |-> code_ff != tws_pkg::CODE_IDLE)
		else $error("flag set with idle status");

endmodule

`default_nettype wire

// ---- dv/tws_slave.sv ----
`timescale 1ns/10ps
`default_nettype none

module tws_slave (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       ack_en_i,
	input  wire logic       slow_i,
	output logic            scl_pull_o,
	output logic            sda_pull_o,
	output logic [7:0]      byte_o,
	output int              nstart_o
);
	int cnt;

	// Lines released, nothing seen yet
	initial
	begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
		byte_o = 8'h00;
		nstart_o = 0;
		cnt = 0;
	end

	// Framing edges of the data line while clock high
	always @(sda_i)
	begin
		if (scl_i === 1'b1)
		begin
			cnt = 0;
			if (sda_i === 1'b0)
				nstart_o++;
		end
	end

	// Shift in bits, MSB first
	always @(posedge scl_i)
	begin
		if (cnt < 8)
			byte_o = {byte_o[6:0], sda_i};
		cnt++;
	end

	// Drive acknowledge in ninth bit, stretch clock when slow
	always @(negedge scl_i)
	begin
		sda_pull_o = (cnt == 8) && ack_en_i;
		if (cnt == 9)
			cnt = 0;
		if (slow_i)
		begin
			scl_pull_o = 1'b1;
			#300;
			scl_pull_o = 1'b0;
		end
	end
endmodule

`default_nettype wire

// ---- dv/tb_two_wire_master_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_two_wire_master_sequencer;
	logic        core_clk, nrst, psel, penable, pwrite, gie;
	logic        ack_en, slow, err;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, rd;
	logic [1:0]  ps;
	wire  [31:0] prdata;
	wire  [7:0]  s_byte;
	wire         pready, pslverr, irq, scl_oe, sda_oe;
	wire         s_scl, s_sda, scl_w, sda_w;
	int          n_fail, cmp_count, ns;

	// Wired lines with pull-up
	assign scl_w = ~(scl_oe | s_scl);
	assign sda_w = ~(sda_oe | s_sda);

	tws_master #(.QUARTER(2)) tws_master_inst (
		.core_clk_i(core_clk), .nrst_i(nrst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .global_irq_en_i(gie), .irq_o(irq),
		.scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
		.sda_o(), .sda_oe_o(sda_oe)
	);

	tws_slave tws_slave_inst (
		.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .slow_i(slow),
		.scl_pull_o(s_scl), .sda_pull_o(s_sda), .byte_o(s_byte),
		.nstart_o(ns)
	);

	// Clock at 20 MHz
	always #25 core_clk = ~core_clk;

	task print_verdict;
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Expected status word from code and prescaler
	function automatic logic [31:0] exp_stat(input logic [4:0] code,
			input logic [1:0] p);
		exp_stat = 32'h0;
		exp_stat[tws_pkg::STAT_CODE_LSB +: 5] = code;
		exp_stat[tws_pkg::STAT_PS_LSB +: 2] = p;
	endfunction

	// One APB transfer, setup then access until ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			n_fail++;
	endtask

	// Poll control until the flag is up
	task wait_flag;
		int k;
		k = 0;
		rd = 32'h0;
		while (rd[7] !== 1'b1 && k < 300)
		begin
			apb(1'b0, tws_pkg::CTRL_OFF, 32'h0);
			k++;
		end
		chk(rd[7], 1'b1);
	endtask

	// Launch an operation and check the posted status
	task op(input logic [7:0] c, input logic [4:0] code);
		apb(1'b1, tws_pkg::CTRL_OFF, {24'h0, c});
		wait_flag();
		apb(1'b0, tws_pkg::STAT_OFF, 32'h0);
		chk(rd, exp_stat(code, ps));
		chk(scl_oe, 1'b1);
	endtask

	// Watchdog
	initial
	begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		nrst = 1'b0;
		{psel, penable, pwrite, gie, ack_en, slow} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(35706));
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		apb(1'b0, tws_pkg::STAT_OFF, 32'h0);
		chk(rd, exp_stat(tws_pkg::CODE_IDLE, tws_pkg::PS_RST));
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, tws_pkg::DATA_OFF, 32'h5A);
		apb(1'b0, tws_pkg::CTRL_OFF, 32'h0);
		chk(rd, 32'h08);
		ps = 2'($urandom);
		apb(1'b1, tws_pkg::STAT_OFF, {30'h0, ps});
		for (int i = 0; i < 4; i++)
		begin
			ack_en <= i[0];
			slow <= i[1];
			gie <= i[1];
			b = {7'($urandom), 1'b0};
			op(8'hA4, tws_pkg::CODE_START);
			chk(ns, i + 1);
			apb(1'b0, tws_pkg::CTRL_OFF, 32'h0);
			chk(rd[5], 1'b0);
			apb(1'b1, tws_pkg::DATA_OFF, {24'h0, b});
			op(8'h84, i[0] ? tws_pkg::CODE_ADDR_ACK
				: tws_pkg::CODE_ADDR_NACK);
			chk(s_byte, b);
			b = 8'($urandom);
			apb(1'b1, tws_pkg::DATA_OFF, {24'h0, b});
			op(8'h84, i[0] ? tws_pkg::CODE_DATA_ACK
				: tws_pkg::CODE_DATA_NACK);
			chk(s_byte, b);
			apb(1'b0, tws_pkg::DATA_OFF, 32'h0);
			chk(rd, {24'h0, b});
			// Control write without flag bit must not launch
			apb(1'b1, tws_pkg::CTRL_OFF, 32'h25);
			repeat (40) @(posedge core_clk);
			chk(ns, i + 1);
			chk(irq, i[1]);
			apb(1'b0, tws_pkg::CTRL_OFF, 32'h0);
			chk(rd[7], 1'b1);
			apb(1'b1, tws_pkg::CTRL_OFF, 32'h94);
			repeat (60) @(posedge core_clk);
			apb(1'b0, tws_pkg::CTRL_OFF, 32'h0);
			chk(rd[7], 1'b0);
			chk({scl_oe, sda_oe, irq}, 3'h0);
		end
		print_verdict();
	end
endmodule

`default_nettype wire
